// >>> pkg/mtc_pkg.sv
// package for the multimode 16-bit timer/counter: map, fields, encodings, timing
package mtc_pkg;
	localparam int ADDR_W = 8;                  // register bus address width
	localparam int DATA_W = 32;                 // register bus data width
	localparam int CNT_W  = 16;                 // counter, period and capture width
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CAPT   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_COUNT  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h10;
	// operating modes
	typedef enum logic [2:0] {
		MODE_TIMER,
		MODE_EXT_TRIG,
		MODE_EVENT,
		MODE_WINDOW,
		MODE_PULSE_WIDTH
	} mtc_mode_t;
	// control register layout, lsb last
	typedef struct packed {
		logic [19:0] rsvd;                      // reads zero
		logic        low_speed_mode;            // bit 11
		logic        prescaler_divider_select;  // bit 10
		logic        auto_capture_enable;       // bit 9
		logic        capture_edge_mode;         // bit 8, 1 = single edge
		logic        trigger_stop_select;       // bit 7
		mtc_mode_t   mode;                      // bits 6:4
		logic [1:0]  source_clock_select;       // bits 3:2
		logic [1:0]  start_control;             // bits 1:0
	} mtc_ctrl_t;
	localparam logic [11:0] CTRL_WMASK = 12'hFFF;  // writable control bits
	localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
	localparam logic [CNT_W-1:0] PERIOD_RST = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	// start control encodings
	localparam logic [1:0] START_STOP    = 2'h0;
	localparam logic [1:0] START_CMD     = 2'h1;
	localparam logic [1:0] START_RISING  = 2'h2;
	localparam logic [1:0] START_FALLING = 2'h3;
	// source clock select encodings and divider exponents of the system and low-frequency clocks
	localparam logic [1:0] CLK_SEL_SLOW = 2'h0;
	localparam logic [1:0] CLK_SEL_MID  = 2'h1;
	localparam logic [1:0] CLK_SEL_FAST = 2'h2;
	localparam int DIV_EXP_SLOW = 11;           // system clock / 2^11
	localparam int DIV_EXP_MID  = 7;            // system clock / 2^7
	localparam int DIV_EXP_FAST = 3;            // system clock / 2^3
	localparam int FS_DIV_EXP   = 3;            // low-frequency clock / 2^3
	// input noise filter, in system clock cycles
	localparam int NOISE_REJECT_CYC = 4;
	localparam int NOISE_PASS_CYC   = 12;
	localparam logic [3:0] FILT_CYC = 4'((NOISE_REJECT_CYC + NOISE_PASS_CYC) / 2);
	// status bit positions
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_ARM_BIT = 1;
	localparam int STAT_PIN_BIT = 2;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/mtc_timer.sv
// multimode 16-bit timer/counter with axi4-lite register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - timer mode: count ticks, match interrupts, clears
// - auto-capture copies counter every source edge in timer, event and window modes
// - auto-capture updates only while enabled and running
// - clock select gives three dividers, slow-only low
// - external trigger: idle until selected edge or start command
// - stop-select one: opposite edge halts, no interrupt
// - stop-select zero: match halts, edges ignored
// - filter rejects short pulses, off in low-speed
// - event mode counts selected input edges
// - event match checked on opposite edge
// - window mode counts ticks gated by input
// - single capture: opposite edge captures, halts
// - double capture: both edges capture, trigger clears
// - after single capture counter holds at one
// - period takes effect after upper byte written
// - start encodings: stop, command, rising, falling
// - stop power mode forces start field to stop
module mtc_timer
	import mtc_pkg::*;
(
	input  wire logic              CLK_I,
	input  wire logic              RST_N_I,
	input  wire logic              TIMER_INPUT_PIN_I,
	input  wire logic              LOW_FREQ_CLOCK_I,
	input  wire logic              STOP_MODE_I,
	output logic                   TIMER_MATCH_INTERRUPT_O,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	input  wire logic [DATA_W-1:0] S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	output logic [1:0]             S_AXI_BRESP_O,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	output logic [DATA_W-1:0]      S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I
);

	mtc_ctrl_t             ctrl_q;         // control register
	logic [CNT_W-1:0]      period_q;       // active period compare value
	logic [CNT_W-1:0]      period_buf_q;   // staged value from the bus
	logic                  period_arm_q;   // upper byte written, load pending
	logic [CNT_W-1:0]      cnt_q;          // up-counter
	logic [CNT_W-1:0]      cnt_d;
	logic [CNT_W-1:0]      cap_q;          // capture register
	logic [CNT_W-1:0]      cap_d;
	logic                  run_q;          // counter running
	logic                  run_d;
	logic                  irq_q;          // interrupt pulse
	logic                  irq_d;
	logic [DIV_EXP_SLOW-1:0] pre_q;        // free running prescaler
	logic [FS_DIV_EXP-1:0] fs_div_q;       // low-frequency divider
	logic                  fs_s1_q;        // low-frequency clock synchroniser
	logic                  fs_s2_q;
	logic                  fs_d_q;         // delayed for edge detect
	logic                  pin_s1_q;       // input pin synchroniser
	logic                  pin_s2_q;
	logic                  pin_f_q;        // filtered input level
	logic                  pin_d_q;        // filtered level one cycle ago
	logic [3:0]            filt_q;         // filter stability count
	// bus state
	logic                  aw_got_q;
	logic                  w_got_q;
	logic [ADDR_W-1:0]     awaddr_q;
	logic [DATA_W-1:0]     wdata_q;
	logic [3:0]            wstrb_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  rvalid_q;
	logic [DATA_W-1:0]     rdata_q;
	logic [1:0]            rresp_q;

	// decoded strobes and events
	wire logic fs_rise     = fs_s2_q & ~fs_d_q;
	wire logic fs_tick     = fs_rise & (&fs_div_q);
	wire logic use_fs      = ctrl_q.low_speed_mode | ctrl_q.prescaler_divider_select;
	wire logic sel_slow    = ctrl_q.source_clock_select == CLK_SEL_SLOW;
	wire logic sel_mid     = ctrl_q.source_clock_select == CLK_SEL_MID;
	wire logic sel_fast    = ctrl_q.source_clock_select == CLK_SEL_FAST;
	// low-speed mode only offers the slow selection; the reserved code never ticks
	wire logic fc_tick     = (sel_slow & (&pre_q))
	                       | (sel_mid & (&pre_q[DIV_EXP_MID-1:0]))
	                       | (sel_fast & (&pre_q[DIV_EXP_FAST-1:0]));
	wire logic src_tick    = use_fs ? (sel_slow & fs_tick) : fc_tick;
	wire logic pin_rise    = pin_f_q & ~pin_d_q;
	wire logic pin_fall    = ~pin_f_q & pin_d_q;
	wire logic start_off   = ctrl_q.start_control == START_STOP;
	wire logic start_cmd   = ctrl_q.start_control == START_CMD;
	wire logic edge_rising = ctrl_q.start_control == START_RISING;
	wire logic trig_edge   = edge_rising ? pin_rise : pin_fall;
	wire logic opp_edge    = edge_rising ? pin_fall : pin_rise;
	// window gate: positive logic on rising code, negative on falling code
	wire logic win_open    = edge_rising ? pin_f_q : ~pin_f_q;
	wire logic match       = cnt_q == period_q;
	wire logic [CNT_W-1:0] cnt_inc = cnt_q + CNT_ONE;
	// source edge of the counter: input edge in event mode, tick otherwise
	wire logic src_edge    = (ctrl_q.mode == MODE_EVENT) ? trig_edge : src_tick;
	wire logic acap_mode   = (ctrl_q.mode == MODE_TIMER) | (ctrl_q.mode == MODE_EVENT)
	                       | (ctrl_q.mode == MODE_WINDOW);
	// bus decode
	wire logic wr_fire     = aw_got_q & w_got_q & ~bvalid_q;
	wire logic wr_ctrl     = wr_fire & (awaddr_q == OFF_CTRL);
	wire logic wr_period   = wr_fire & (awaddr_q == OFF_PERIOD);
	wire logic wr_ro       = (awaddr_q == OFF_CAPT) | (awaddr_q == OFF_COUNT)
	                       | (awaddr_q == OFF_STAT);
	wire logic wr_ok       = (awaddr_q == OFF_CTRL) | (awaddr_q == OFF_PERIOD) | wr_ro;
	wire logic rd_fire     = S_AXI_ARVALID_I & ~rvalid_q;
	wire logic [DATA_W-1:0] stat_word = DATA_W'({pin_f_q, period_arm_q, run_q});
	wire logic rd_hit      = (S_AXI_ARADDR_I == OFF_CTRL) | (S_AXI_ARADDR_I == OFF_PERIOD)
	                       | (S_AXI_ARADDR_I == OFF_CAPT) | (S_AXI_ARADDR_I == OFF_COUNT)
	                       | (S_AXI_ARADDR_I == OFF_STAT);
	wire logic [DATA_W-1:0] rd_word =
		(S_AXI_ARADDR_I == OFF_CTRL)   ? DATA_W'(ctrl_q) :
		(S_AXI_ARADDR_I == OFF_PERIOD) ? DATA_W'(period_q) :
		(S_AXI_ARADDR_I == OFF_CAPT)   ? DATA_W'(cap_q) :
		(S_AXI_ARADDR_I == OFF_COUNT)  ? DATA_W'(cnt_q) :
		(S_AXI_ARADDR_I == OFF_STAT)   ? stat_word : '0;

	// prescaler and low-frequency divider
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pre_q    <= '0;
			fs_div_q <= '0;
		end else begin
			pre_q <= pre_q + 1'b1;
			if (fs_rise) begin
				fs_div_q <= fs_div_q + 1'b1;
			end
		end
	end

	// synchronisers: first stages feed only the second stages
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			fs_s1_q  <= 1'b0;
			fs_s2_q  <= 1'b0;
			fs_d_q   <= 1'b0;
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			fs_s1_q  <= LOW_FREQ_CLOCK_I;
			fs_s2_q  <= fs_s1_q;
			fs_d_q   <= fs_s2_q;
			pin_s1_q <= TIMER_INPUT_PIN_I;
			pin_s2_q <= pin_s1_q;
		end
	end

	// noise filter: a level must persist FILT_CYC cycles to be taken
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pin_f_q <= 1'b0;
			pin_d_q <= 1'b0;
			filt_q  <= '0;
		end else begin
			pin_d_q <= pin_f_q;
			if (ctrl_q.low_speed_mode) begin
				pin_f_q <= pin_s2_q;
				filt_q  <= '0;
			end else if (pin_s2_q != pin_f_q) begin
				// short glitches restart the count and never reach the output
				if (filt_q == FILT_CYC - 4'h1) begin
					pin_f_q <= pin_s2_q;
					filt_q  <= '0;
				end else begin
					filt_q <= filt_q + 4'h1;
				end
			end else begin
				filt_q <= '0;
			end
		end
	end

	// counter behaviour per mode
	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		cap_d = cap_q;
		irq_d = 1'b0;
		if (start_off) begin
			// stop code clears the counter and drops the run flag
			cnt_d = '0;
			run_d = 1'b0;
		end else begin
			unique case (ctrl_q.mode)
				MODE_TIMER: begin
					if (start_cmd | trig_edge) begin
						run_d = 1'b1;
					end
					if (run_q & src_tick) begin
						if (match) begin
							cnt_d = '0;
							irq_d = 1'b1;
						end else begin
							cnt_d = cnt_inc;
						end
					end
				end
				MODE_EXT_TRIG: begin
					if (!run_q) begin
						// idle until trigger; trigger while running is ignored
						run_d = trig_edge | start_cmd;
					end else if (ctrl_q.trigger_stop_select & opp_edge) begin
						cnt_d = '0;
						run_d = 1'b0;
					end else if (src_tick) begin
						if (match) begin
							cnt_d = '0;
							run_d = 1'b0;
							irq_d = 1'b1;
						end else begin
							cnt_d = cnt_inc;
						end
					end
				end
				MODE_EVENT: begin
					run_d = 1'b1;
					if (trig_edge) begin
						cnt_d = cnt_inc;
					end else if (opp_edge & match) begin
						cnt_d = '0;
						irq_d = 1'b1;
					end
				end
				MODE_WINDOW: begin
					run_d = 1'b1;
					if (src_tick & win_open) begin
						if (match) begin
							cnt_d = '0;
							irq_d = 1'b1;
						end else begin
							cnt_d = cnt_inc;
						end
					end
				end
				MODE_PULSE_WIDTH: begin
					if (!run_q) begin
						// counter holds its value (one after a single capture)
						run_d = trig_edge;
					end else if (opp_edge) begin
						cap_d = cnt_q;
						irq_d = 1'b1;
						if (ctrl_q.capture_edge_mode) begin
							cnt_d = CNT_ONE;
							run_d = 1'b0;
						end
					end else if (trig_edge) begin
						cap_d = cnt_q;
						irq_d = 1'b1;
						cnt_d = '0;
					end else if (src_tick) begin
						cnt_d = cnt_inc;
					end
				end
				default: begin
					run_d = 1'b0;
				end
			endcase
			// auto-capture follows the running counter on every source edge in timer, event and window modes
			if (ctrl_q.auto_capture_enable & acap_mode & run_q & src_edge) begin
				cap_d = cnt_q;
			end
		end
	end

	// counter, capture and interrupt registers
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			cnt_q <= '0;
			cap_q <= '0;
			run_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			cap_q <= cap_d;
			run_q <= run_d;
			irq_q <= irq_d;
		end
	end

	// control and period registers; period loads on the source edge after arming
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ctrl_q       <= mtc_ctrl_t'(CTRL_RST);
			period_q     <= PERIOD_RST;
			period_buf_q <= PERIOD_RST;
			period_arm_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= mtc_ctrl_t'(DATA_W'(wdata_q[11:0] & CTRL_WMASK));
			end
			// stop power mode overrides the start field of a bus write in the same cycle
			if (STOP_MODE_I) begin
				ctrl_q.start_control <= START_STOP;
			end
			if (wr_period & wstrb_q[0]) begin
				period_buf_q[7:0] <= wdata_q[7:0];
			end
			if (wr_period & wstrb_q[1]) begin
				period_buf_q[15:8] <= wdata_q[15:8];
				period_arm_q       <= 1'b1;
			end else if (period_arm_q & src_edge) begin
				period_q     <= period_buf_q;
				period_arm_q <= 1'b0;
			end
		end
	end

	// write channel: address and data taken in either order, then one response
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
				aw_got_q <= 1'b1;
				awaddr_q <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
				w_got_q <= 1'b1;
				wdata_q <= S_AXI_WDATA_I;
				wstrb_q <= S_AXI_WSTRB_I;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q & S_AXI_BREADY_I) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read channel: one cycle from address to data
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q & S_AXI_RREADY_I) begin
			rvalid_q <= 1'b0;
		end
	end

	// outputs
	assign S_AXI_AWREADY_O         = ~aw_got_q & ~bvalid_q;
	assign S_AXI_WREADY_O          = ~w_got_q & ~bvalid_q;
	assign S_AXI_BVALID_O          = bvalid_q;
	assign S_AXI_BRESP_O           = bresp_q;
	assign S_AXI_ARREADY_O         = ~rvalid_q;
	assign S_AXI_RVALID_O          = rvalid_q;
	assign S_AXI_RDATA_O           = rdata_q;
	assign S_AXI_RRESP_O           = rresp_q;
	assign TIMER_MATCH_INTERRUPT_O = irq_q;

endmodule

// >>> bench/mtc_chk.sv
// concurrent checks on the timer block's bus and interrupt ports
`timescale 1ns/1ps
module mtc_chk
	import mtc_pkg::*;
(
	input wire logic              CLK_I,
	input wire logic              RST_N_I,
	input wire logic              STOP_MODE_I,
	input wire logic              TIMER_MATCH_INTERRUPT_O,
	input wire logic              S_AXI_AWVALID_I,
	input wire logic              S_AXI_AWREADY_O,
	input wire logic              S_AXI_WVALID_I,
	input wire logic              S_AXI_WREADY_O,
	input wire logic [1:0]        S_AXI_BRESP_O,
	input wire logic              S_AXI_BVALID_O,
	input wire logic              S_AXI_BREADY_I,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic              S_AXI_ARVALID_I,
	input wire logic              S_AXI_ARREADY_O,
	input wire logic [DATA_W-1:0] S_AXI_RDATA_O,
	input wire logic [1:0]        S_AXI_RRESP_O,
	input wire logic              S_AXI_RVALID_O,
	input wire logic              S_AXI_RREADY_I
);
	// one clock domain, so one default clock and reset
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// both write channels taken on one edge
	sequence s_wr_take;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence s_rd_take;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	// held long enough that a pulse launched just before has drained
	sequence s_stop_held;
		STOP_MODE_I [*5];
	endsequence
	property p_wr_resp;
		// both halves are latched first, the answer is raised one cycle later
		s_wr_take |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O ##1 S_AXI_BVALID_O;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_b_hold;
		S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_rd_lat;
		s_rd_take |=> S_AXI_RVALID_O;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_ar_block;
		S_AXI_RVALID_O |-> !S_AXI_ARREADY_O;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	// unmapped reads answer an error with zero data
	property p_rd_err;
		s_rd_take ##0 (S_AXI_ARADDR_I > OFF_STAT)
			|=> S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == '0;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read answer");
	property p_rd_ok;
		s_rd_take ##0 (S_AXI_ARADDR_I <= OFF_STAT && S_AXI_ARADDR_I[1:0] == 2'h0)
			|=> S_AXI_RRESP_O == RESP_OKAY;
	endproperty
	a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
	property p_irq_pulse;
		TIMER_MATCH_INTERRUPT_O |=> !TIMER_MATCH_INTERRUPT_O;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
	property p_stop_quiet;
		s_stop_held |-> !TIMER_MATCH_INTERRUPT_O;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("interrupt in stop");
endmodule
bind mtc_timer mtc_chk mtc_chk_i (.*);

// >>> bench/mtc_src.sv
// model of the external pulse source on the timer input pin
`timescale 1ns/1ps
module mtc_src
	import mtc_pkg::*;
(
	input  wire logic clk_i, // system clock
	output logic      pin_o  // driven level, never released
);
	initial pin_o = 1'b0;
	// hold a level; phases never shorter than the filter's pass width
	task automatic drive(input logic lvl, input int cyc);
		pin_o <= lvl;
		repeat ((cyc < NOISE_PASS_CYC) ? NOISE_PASS_CYC : cyc) @(posedge clk_i);
	endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the multimode timer/counter
`timescale 1ns/1ps
module tb
	import mtc_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;     // active-low reset
	logic              stop_mode = 1'b0;
	logic              lfc = 1'b0;       // low-frequency clock
	mtc_ctrl_t         lc;               // control word for the low-speed checks
	logic              pin, irq;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, d, a, b, c, e;
	logic [3:0]        wstrb = '0;
	logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	int                failures = 0, cmp_count = 0, irq_n = 0, n, m;
	logic [ADDR_W-1:0] offs[5] = '{OFF_CTRL, OFF_PERIOD, OFF_CAPT, OFF_COUNT, OFF_STAT};
	logic [DATA_W-1:0] rv[5] = '{CTRL_RST, {16'h0000, PERIOD_RST}, '0, '0, '0};
	logic [1:0]        cks[3] = '{CLK_SEL_FAST, CLK_SEL_MID, CLK_SEL_SLOW};
	int                exs[3] = '{DIV_EXP_FAST, DIV_EXP_MID, DIV_EXP_SLOW};

	mtc_timer mtc_timer_i (
		.CLK_I(clk), .RST_N_I(rst_n), .TIMER_INPUT_PIN_I(pin), .LOW_FREQ_CLOCK_I(lfc),
		.STOP_MODE_I(stop_mode), .TIMER_MATCH_INTERRUPT_O(irq),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
	);
	mtc_src mtc_src_i (.clk_i(clk), .pin_o(pin));

	// 40 MHz system clock
	initial forever #12.5 clk = ~clk;
	// low-frequency clock of 16 system cycles; it toggles on falling system edges only
	initial forever #200 lfc = ~lfc;
	// interrupt pulses counted so checks need not race the pin driver
	always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;

	task automatic finish_test;
		$display("cmp_count=%0d failures=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	// a wait that ran out ends the run
	task automatic guard(input logic to);
		if (to) begin
			failures++;
			$display("[FAIL] %0t wait timed out", $time);
			finish_test;
		end
	endtask
	// one write; ready accepted late so the answer must stand
	task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt,
			input logic [3:0] sb, input logic [1:0] er);
		logic pa, pw;
		int k;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= ad;
		wdata <= dt;
		wstrb <= sb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (k = 0; k < 40 && (pa || pw); k++) begin
			@(posedge clk);
			if (pa && awready === 1'b1) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready === 1'b1) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		for (; k < 40 && bvalid !== 1'b1; k++) @(posedge clk);
		guard(k >= 40);
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
		chk(bresp === er, "write response");
	endtask
	task automatic rd(input logic [ADDR_W-1:0] ad, output logic [DATA_W-1:0] dt,
			input logic [1:0] er);
		int k;
		araddr <= ad;
		arvalid <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (arready === 1'b1) break;
		end
		arvalid <= 1'b0;
		for (; k < 40 && rvalid !== 1'b1; k++) @(posedge clk);
		guard(k >= 40);
		rready <= 1'b1;
		@(posedge clk);
		dt = rdata;
		rready <= 1'b0;
		chk(rresp === er, "read response");
	endtask
	// cycles since the previous interrupt pulse
	task automatic wait_irq(output int cy);
		for (cy = 1; cy <= 6000; cy++) begin
			@(posedge clk);
			if (irq === 1'b1) break;
		end
		guard(cy > 6000);
	endtask
	function automatic logic [DATA_W-1:0] cw(mtc_mode_t md, logic [1:0] st, logic [1:0] ck,
			logic [2:0] f);
		mtc_ctrl_t r;
		r = '0;
		r.mode = md;
		r.start_control = st;
		r.source_clock_select = ck;
		{r.auto_capture_enable, r.capture_edge_mode, r.trigger_stop_select} = f;
		return r;
	endfunction
	// mode changes only while stopped, then start
	task automatic go(input mtc_mode_t md, input logic [1:0] st, input logic [1:0] ck,
			input logic [2:0] f);
		wr(OFF_CTRL, cw(md, START_STOP, ck, f), 4'hF, RESP_OKAY);
		wr(OFF_CTRL, cw(md, st, ck, f), 4'hF, RESP_OKAY);
	endtask
	// one 80-cycle input phase, capture read well before the next trigger
	task automatic phase(input logic lvl, output logic [DATA_W-1:0] cap);
		fork
			mtc_src_i.drive(lvl, 80);
			begin
				repeat (20) @(posedge clk);
				rd(OFF_CAPT, cap, RESP_OKAY);
			end
		join
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++) begin
			rd(offs[i], d, RESP_OKAY);
			chk(d === rv[i], "reset value");
		end
		rd(8'h40, d, RESP_SLVERR);
		chk(d === 32'h0, "unmapped read data");
		wr(8'h40, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
		wr(OFF_PERIOD, 32'h1, 4'hF, RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			go(MODE_TIMER, START_CMD, cks[i], 3'h0);
			wait_irq(n);
			wait_irq(n);
			chk(n == (2 << exs[i]), "tick rate");
		end
		// low-speed: slow select counts the low clock, the mid select never ticks
		lc = cw(MODE_TIMER, START_CMD, CLK_SEL_SLOW, 3'h0);
		lc.low_speed_mode = 1'b1;
		wr(OFF_CTRL, lc, 4'hF, RESP_OKAY);
		wait_irq(n);
		wait_irq(n);
		chk(n == (2 << FS_DIV_EXP) * 16, "low-speed tick rate");
		lc.source_clock_select = CLK_SEL_MID;
		wr(OFF_CTRL, lc, 4'hF, RESP_OKAY);
		m = irq_n;
		repeat (600) @(posedge clk);
		chk(irq_n == m, "low-speed mid select ticked");
		go(MODE_TIMER, START_CMD, CLK_SEL_FAST, 3'h0);
		wr(OFF_PERIOD, 32'h7, 4'h1, RESP_OKAY);
		wait_irq(n);
		wait_irq(n);
		chk(n == 16, "low byte alone applied");
		wr(OFF_PERIOD, 32'h0, 4'h2, RESP_OKAY);
		wait_irq(n);
		wait_irq(n);
		chk(n == 64, "period after high byte");
		go(MODE_TIMER, START_CMD, CLK_SEL_FAST, 3'h4);
		wait_irq(n);
		// the pulse comes one cycle after a tick; both reads then fall between two ticks
		repeat (17) @(posedge clk);
		rd(OFF_CAPT, a, RESP_OKAY);
		rd(OFF_COUNT, b, RESP_OKAY);
		chk(b[15:0] === a[15:0] + 16'h1 && a[15:0] !== 16'h0, "auto capture lag");
		wr(OFF_CTRL, cw(MODE_TIMER, START_STOP, CLK_SEL_FAST, 3'h0), 4'hF, RESP_OKAY);
		rd(OFF_COUNT, b, RESP_OKAY);
		chk(b === 32'h0, "stop clears count");
		go(MODE_TIMER, START_CMD, CLK_SEL_FAST, 3'h0);
		stop_mode <= 1'b1;
		repeat (6) @(posedge clk);
		stop_mode <= 1'b0;
		rd(OFF_CTRL, d, RESP_OKAY);
		chk(d[1:0] === START_STOP, "stop mode start field");
		m = irq_n;
		repeat (100) @(posedge clk);
		chk(irq_n == m, "timer kept running");
		go(MODE_EXT_TRIG, START_RISING, CLK_SEL_FAST, 3'h0);
		m = irq_n;
		repeat (100) @(posedge clk);
		chk(irq_n == m, "count before trigger");
		mtc_src_i.drive(1'b1, 30);
		mtc_src_i.drive(1'b0, 150);
		chk(irq_n == m + 1, "match halt, fall ignored");
		go(MODE_EXT_TRIG, START_RISING, CLK_SEL_FAST, 3'h1);
		mtc_src_i.drive(1'b1, 30);
		mtc_src_i.drive(1'b0, 150);
		chk(irq_n == m + 1, "opposite edge halt");
		mtc_src_i.drive(1'b1, 150);
		chk(irq_n == m + 2, "trigger restart");
		mtc_src_i.drive(1'b0, 20);
		go(MODE_WINDOW, START_FALLING, CLK_SEL_FAST, 3'h0);
		m = irq_n;
		mtc_src_i.drive(1'b1, 200);
		chk(irq_n == m, "gate closed");
		mtc_src_i.drive(1'b0, 100);
		chk(irq_n == m + 1, "gate open");
		go(MODE_EVENT, START_RISING, CLK_SEL_FAST, 3'h0);
		m = irq_n;
		for (int i = 0; i < 7; i++) begin
			mtc_src_i.drive(1'b1, 20);
			if (i == 6) chk(irq_n == m, "match on count edge");
			mtc_src_i.drive(1'b0, 20);
		end
		chk(irq_n == m + 1, "event match");
		wr(OFF_PERIOD, 32'hFFFF, 4'hF, RESP_OKAY);
		go(MODE_PULSE_WIDTH, START_RISING, CLK_SEL_FAST, 3'h2);
		m = irq_n;
		phase(1'b1, d);
		phase(1'b0, a);
		phase(1'b1, d);
		phase(1'b0, b);
		chk(b === a + 32'h1, "single capture offset");
		chk(irq_n == m + 2, "single capture interrupts");
		go(MODE_PULSE_WIDTH, START_RISING, CLK_SEL_FAST, 3'h0);
		phase(1'b1, d);
		phase(1'b0, d);
		m = irq_n;
		phase(1'b1, d);
		phase(1'b0, c);
		phase(1'b1, e);
		// equal phases: the cycle is twice the high width whatever the tick phase
		chk(e === c + c, "double capture spacing");
		chk(irq_n == m + 3, "double capture interrupts");
		finish_test;
	end
endmodule
